// ===== rtl/blit_pkg.sv
// Shared types and timing constants of the branch and load/store issue timing block.
package blit_pkg;
  typedef enum logic [3:0] {
    CL_OTHER, CL_BRANCH, CL_LINK_RET, CL_REG_BR, CL_SR_READ, CL_SR_WRITE,
    CL_MASK_CHANGE, CL_ENDIAN, CL_LOADSTORE, CL_PRELOAD, CL_PC_LOAD
  } blit_class_t;
  typedef enum logic {ST_IDLE, ST_BUSY} blit_state_t;
  localparam int ADDR_W = 32;
  localparam int RS_DEPTH = 3;
  localparam logic [1:0] RS_FULL = 2'h3;
  localparam logic [3:0] CYC_FOLDED = 4'h0;
  localparam logic [3:0] CYC_DYN = 4'h1;
  localparam logic [3:0] CYC_STATIC_NT = 4'h1;
  localparam logic [3:0] CYC_STATIC_T = 4'h4;
  localparam logic [3:0] MISP_MAX = 4'h7;
  localparam logic [3:0] MISP_MIN = 4'h5;
  localparam logic [2:0] DIST_SAT = 3'h7;
  localparam logic [3:0] RS_HIT = 4'h4;
  localparam logic [3:0] RS_MISS = 4'h7;
  localparam logic [3:0] RS_EMPTY = 4'h5;
  localparam logic [3:0] REG_NOT_TAKEN = 4'h1;
  localparam logic [3:0] SR_READ = 4'h1;
  localparam logic [3:0] SR_FLAGS = 4'h2;
  localparam logic [3:0] SR_OTHER = 4'h4;
  localparam logic [3:0] SR_SAVED = 4'h5;
  localparam logic [3:0] MASK_ONLY = 4'h1;
  localparam logic [3:0] MASK_MODE = 4'h2;
  localparam logic [3:0] ENDIAN_CYC = 4'h1;
  localparam logic [3:0] ONE_ISSUE = 4'h1;
  localparam logic [3:0] TWO_ISSUE = 4'h2;
  localparam logic [3:0] LOAD_LAT_ADD = 4'h2;
  localparam logic [3:0] BASE_LAT = 4'h1;
  localparam logic [3:0] BASE_FWD_LAT = 4'h0;
  localparam logic [3:0] PCL_RET_HIT = 4'h4;
  localparam logic [3:0] PCL_RET_MISS = 4'h9;
  localparam logic [3:0] PCL_COND_RET = 4'h8;
  localparam logic [3:0] PCL_ONE = 4'h8;
  localparam logic [3:0] PCL_TWO = 4'h9;
endpackage : blit_pkg

// ===== rtl/blit_rs_if.sv
// Connection between the issue controller and its return prediction stack.
`timescale 1ns/1ps
interface blit_rs_if;
  logic push;
  logic pop;
  logic [blit_pkg::ADDR_W-1:0] push_addr;
  logic [blit_pkg::ADDR_W-1:0] top;
  logic empty;
  modport ctrl (output push, output pop, output push_addr, input top, input empty);
  modport stack (input push, input pop, input push_addr, output top, output empty);
endinterface : blit_rs_if

// ===== rtl/blit_ret_stack.sv
// Three-entry return prediction stack that drops its oldest entry when full.
`timescale 1ns/1ps
module blit_ret_stack (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Stack port.
  blit_rs_if.stack rs
);
  logic [blit_pkg::ADDR_W-1:0] ent_reg [blit_pkg::RS_DEPTH];
  wire logic [blit_pkg::ADDR_W-1:0] ent_next [blit_pkg::RS_DEPTH];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic pop_ok;

  // A pop of an empty stack is ignored.
  assign pop_ok = rs.pop && (cnt_reg != 2'h0);
  assign rs.top = ent_reg[0];
  assign rs.empty = (cnt_reg == 2'h0);

  // Entry zero is the top; a push shifts down and the oldest falls off the end.
  generate
    for (genvar i = 0; i < blit_pkg::RS_DEPTH; i++) begin : g_ent
      wire logic [blit_pkg::ADDR_W-1:0] up_val;
      wire logic [blit_pkg::ADDR_W-1:0] dn_val;
      if (i == 0) begin : g_first
        assign up_val = rs.push_addr;
      end else begin : g_up
        assign up_val = ent_reg[i-1];
      end
      if (i == blit_pkg::RS_DEPTH - 1) begin : g_last
        assign dn_val = 32'h0000_0000;
      end else begin : g_dn
        assign dn_val = ent_reg[i+1];
      end
      assign ent_next[i] = (rs.push && pop_ok) ? ((i == 0) ? rs.push_addr : ent_reg[i]) :
                           rs.push ? up_val : pop_ok ? dn_val : ent_reg[i];
    end
  endgenerate

  // Occupancy saturates at the depth so an overflow keeps the newest entries.
  always_comb begin
    cnt_next = cnt_reg;
    if (rs.push && !pop_ok && (cnt_reg != blit_pkg::RS_FULL)) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop_ok && !rs.push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // Stack storage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ent_reg <= '{default: 32'h0000_0000};
      cnt_reg <= 2'h0;
    end else if (ce) begin
      ent_reg <= ent_next;
      cnt_reg <= cnt_next;
    end
  end

  property p_rs_push_top;
    @(posedge clk) disable iff (rst || !ce)
    rs.push |=> (rs.top == $past(rs.push_addr)) && !rs.empty;
  endproperty
  a_rs_push_top: assert property (p_rs_push_top) else $error("pushed address not on top");

  property p_rs_depth;
    @(posedge clk) disable iff (rst || !ce)
    (cnt_reg == blit_pkg::RS_FULL) && rs.push && !rs.pop |=> cnt_reg == blit_pkg::RS_FULL;
  endproperty
  a_rs_depth: assert property (p_rs_depth) else $error("full stack changed depth");
endmodule : blit_ret_stack

// ===== rtl/blit_misp.sv
// Mispredict penalty from the distance to the last flag-setting instruction.
`timescale 1ns/1ps
module blit_misp (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Flag producer and penalty.
  input wire logic flag_set,
  output logic [3:0] cost
);
  logic [2:0] dist_reg;
  logic [2:0] dist_next;
  logic [3:0] gap;

  // Cycles since the last flag setter, saturating.
  always_comb begin
    dist_next = dist_reg;
    if (flag_set) begin
      dist_next = 3'h0;
    end else if (dist_reg != blit_pkg::DIST_SAT) begin
      dist_next = dist_reg + 3'h1;
    end
  end

  // Distance register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dist_reg <= blit_pkg::DIST_SAT;
    end else if (ce) begin
      dist_reg <= dist_next;
    end
  end

  // Penalty is the larger of the shrunk maximum and the floor.
  assign gap = blit_pkg::MISP_MAX - {1'b0, dist_reg};
  assign cost = (gap > blit_pkg::MISP_MIN) ? gap : blit_pkg::MISP_MIN;

  property p_misp_near;
    @(posedge clk) disable iff (rst || !ce)
    flag_set |=> cost == blit_pkg::MISP_MAX;
  endproperty
  a_misp_near: assert property (p_misp_near) else $error("near penalty not seven");

  property p_misp_range;
    @(posedge clk) disable iff (rst)
    (cost >= blit_pkg::MISP_MIN) && (cost <= blit_pkg::MISP_MAX);
  endproperty
  a_misp_range: assert property (p_misp_range) else $error("penalty out of range");
endmodule : blit_misp

// ===== rtl/blit_issue_timing.sv
// Issue timing controller for branches, status updates and single loads and stores.
`timescale 1ns/1ps
module blit_issue_timing (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Instruction offered for issue.
  input wire logic op_valid,
  input wire blit_pkg::blit_class_t op_class,
  input wire logic op_cond,
  input wire logic op_cond_pass,
  input wire logic op_taken,
  input wire logic op_link,
  input wire logic [31:0] op_target,
  input wire logic [31:0] op_ret_addr,
  // Branch prediction state.
  input wire logic pred_dynamic,
  input wire logic pred_dyn_correct,
  input wire logic pred_folded,
  input wire logic pred_static_taken,
  input wire logic flag_set,
  // Status update attributes.
  input wire logic sr_saved,
  input wire logic sr_flags_status_only,
  input wire logic mask_mode_change,
  // Load and store attributes.
  input wire logic ls_load,
  input wire logic ls_reg_offset,
  input wire logic ls_offset_neg,
  input wire logic ls_shift_ok,
  input wire logic ls_writeback,
  input wire logic ls_base_sp,
  input wire logic unaligned_en,
  input wire logic ls_operand_unaligned,
  input wire logic ls_final_unaligned,
  // Preload outcome.
  input wire logic preload_fault,
  input wire logic preload_hit,
  input wire logic preload_abort,
  // Timing results.
  output logic issue_ready_reg,
  output logic done_reg,
  output logic [3:0] cycles_reg,
  output logic [3:0] mem_cycles_reg,
  output logic [3:0] result_lat_reg,
  output logic result_valid_reg,
  output logic early_base_reg,
  output logic early_offset_reg,
  output logic [3:0] base_lat_reg,
  output logic lsu_hold_reg,
  output logic preload_drop_reg,
  output logic mispredict_reg
);
  blit_rs_if rs_if ();
  logic [3:0] misp_cost;
  logic accept;
  blit_pkg::blit_state_t state_reg;
  blit_pkg::blit_state_t state_next;
  logic [3:0] rem_reg;
  logic [3:0] rem_next;
  logic ready_next;
  logic done_next;
  logic prev_wb_reg;
  logic [3:0] cost;
  logic [3:0] mem;
  logic [3:0] lat;
  logic [3:0] iss;
  logic [3:0] base_lat;
  logic lat_v;
  logic eb;
  logic eo;
  logic hold;
  logic misp;
  logic drop;
  logic push;
  logic pop;
  logic one;
  logic pot;
  logic is_ret;
  logic rs_hit;

  // Single-issue addressing: immediate, or positive register unshifted or shifted by two.
  function automatic logic one_issue(input logic reg_off, input logic neg, input logic sh_ok);
    return !reg_off || (!neg && sh_ok);
  endfunction : one_issue

  blit_ret_stack u_stack (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rs(rs_if.stack)
  );

  blit_misp u_misp (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .flag_set(flag_set),
    .cost(misp_cost)
  );

  // An instruction is taken only while no earlier one is still occupying the pipe.
  assign accept = ce && op_valid && (state_reg == blit_pkg::ST_IDLE);
  assign rs_if.push = accept && push;
  assign rs_if.pop = accept && pop;
  assign rs_if.push_addr = op_ret_addr;

  // Cycle, memory and latency figures for the offered instruction.
  always_comb begin
    one = one_issue(ls_reg_offset, ls_offset_neg, ls_shift_ok);
    iss = one ? blit_pkg::ONE_ISSUE : blit_pkg::TWO_ISSUE;
    pot = unaligned_en && ls_operand_unaligned;
    is_ret = ls_base_sp && !ls_reg_offset;
    rs_hit = !rs_if.empty && (rs_if.top == op_target);
    cost = blit_pkg::CYC_DYN;
    mem = 4'h0;
    lat = 4'h0;
    lat_v = 1'b0;
    eb = 1'b0;
    eo = 1'b0;
    hold = 1'b0;
    misp = 1'b0;
    drop = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    case (op_class)
      blit_pkg::CL_BRANCH: begin
        push = op_link && op_taken;
        if (pred_dynamic && pred_dyn_correct) begin
          cost = pred_folded ? blit_pkg::CYC_FOLDED : blit_pkg::CYC_DYN;
        end else if (!pred_dynamic && (pred_static_taken == op_taken)) begin
          cost = op_taken ? blit_pkg::CYC_STATIC_T : blit_pkg::CYC_STATIC_NT;
        end else begin
          cost = misp_cost;
          misp = 1'b1;
        end
      end
      blit_pkg::CL_LINK_RET: begin
        pop = op_taken && !rs_if.empty;
        if (op_cond) begin
          cost = misp_cost;
          misp = 1'b1;
        end else if (rs_if.empty) begin
          cost = blit_pkg::RS_EMPTY;
        end else if (rs_hit) begin
          cost = blit_pkg::RS_HIT;
        end else begin
          cost = blit_pkg::RS_MISS;
          misp = 1'b1;
        end
      end
      blit_pkg::CL_REG_BR: begin
        push = op_link && op_taken;
        if (op_cond && !op_taken) begin
          cost = blit_pkg::REG_NOT_TAKEN;
        end else begin
          cost = misp_cost;
          misp = 1'b1;
        end
      end
      blit_pkg::CL_SR_READ: cost = blit_pkg::SR_READ;
      blit_pkg::CL_SR_WRITE: begin
        if (sr_saved) begin
          cost = blit_pkg::SR_SAVED;
        end else if (sr_flags_status_only) begin
          cost = blit_pkg::SR_FLAGS;
        end else begin
          cost = blit_pkg::SR_OTHER;
        end
      end
      blit_pkg::CL_MASK_CHANGE: begin
        cost = mask_mode_change ? blit_pkg::MASK_MODE : blit_pkg::MASK_ONLY;
      end
      blit_pkg::CL_ENDIAN: cost = blit_pkg::ENDIAN_CYC;
      blit_pkg::CL_LOADSTORE, blit_pkg::CL_PRELOAD: begin
        eb = one;
        eo = ls_reg_offset;
        hold = pot;
        cost = iss;
        mem = iss + {3'h0, pot};
        lat = iss + blit_pkg::LOAD_LAT_ADD + {3'h0, unaligned_en && ls_final_unaligned};
        lat_v = ls_load && (op_class == blit_pkg::CL_LOADSTORE);
        drop = (op_class == blit_pkg::CL_PRELOAD) &&
               (preload_fault || preload_hit || preload_abort);
      end
      blit_pkg::CL_PC_LOAD: begin
        eb = one;
        eo = ls_reg_offset;
        mem = iss;
        if (!op_cond_pass) begin
          cost = iss;
          lat = iss + blit_pkg::LOAD_LAT_ADD;
          lat_v = 1'b1;
        end else if (is_ret) begin
          pop = !rs_if.empty;
          if (op_cond || rs_if.empty) begin
            cost = blit_pkg::PCL_COND_RET;
          end else if (rs_hit) begin
            cost = blit_pkg::PCL_RET_HIT;
          end else begin
            cost = blit_pkg::PCL_RET_MISS;
            misp = 1'b1;
          end
        end else begin
          cost = one ? blit_pkg::PCL_ONE : blit_pkg::PCL_TWO;
        end
      end
      default: cost = blit_pkg::CYC_DYN;
    endcase
    // Back-to-back writeback accesses see the new base at once.
    base_lat = (prev_wb_reg && ls_writeback) ? blit_pkg::BASE_FWD_LAT : blit_pkg::BASE_LAT;
  end

  // Sequencer: holds issue for all but the last cycle of the instruction.
  always_comb begin
    state_next = state_reg;
    rem_next = rem_reg;
    ready_next = issue_ready_reg;
    done_next = 1'b0;
    case (state_reg)
      blit_pkg::ST_IDLE: begin
        if (accept) begin
          if (cost < 4'h2) begin
            done_next = 1'b1;
          end else begin
            state_next = blit_pkg::ST_BUSY;
            rem_next = cost - 4'h2;
            ready_next = 1'b0;
          end
        end
      end
      blit_pkg::ST_BUSY: begin
        if (rem_reg == 4'h0) begin
          state_next = blit_pkg::ST_IDLE;
          ready_next = 1'b1;
          done_next = 1'b1;
        end else begin
          rem_next = rem_reg - 4'h1;
        end
      end
      default: begin
        state_next = blit_pkg::ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // Sequencer and result registers; results other than the preload drop pulse load when an instruction is taken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= blit_pkg::ST_IDLE;
      rem_reg <= 4'h0;
      issue_ready_reg <= 1'b1;
      done_reg <= 1'b0;
      prev_wb_reg <= 1'b0;
      cycles_reg <= 4'h0;
      mem_cycles_reg <= 4'h0;
      result_lat_reg <= 4'h0;
      result_valid_reg <= 1'b0;
      early_base_reg <= 1'b0;
      early_offset_reg <= 1'b0;
      base_lat_reg <= blit_pkg::BASE_LAT;
      lsu_hold_reg <= 1'b0;
      preload_drop_reg <= 1'b0;
      mispredict_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      rem_reg <= rem_next;
      issue_ready_reg <= ready_next;
      done_reg <= done_next;
      preload_drop_reg <= accept && drop;
      if (accept) begin
        prev_wb_reg <= ls_writeback && (op_class == blit_pkg::CL_LOADSTORE);
        cycles_reg <= cost;
        mem_cycles_reg <= mem;
        result_lat_reg <= lat;
        result_valid_reg <= lat_v;
        early_base_reg <= eb;
        early_offset_reg <= eo;
        base_lat_reg <= base_lat;
        lsu_hold_reg <= hold;
        mispredict_reg <= misp;
      end
    end
  end

  property p_static_taken;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_BRANCH) && !pred_dynamic && pred_static_taken && op_taken
      |=> (cycles_reg == 4'h4) && !mispredict_reg;
  endproperty
  a_static_taken: assert property (p_static_taken) else $error("static taken not 4");

  property p_saved_write;
    @(posedge clk) disable iff (rst || !ce)
    accept && (op_class == blit_pkg::CL_SR_WRITE) && sr_saved
      |=> !issue_ready_reg[*4] ##1 (done_reg && issue_ready_reg && cycles_reg == 4'h5);
  endproperty
  a_saved_write: assert property (p_saved_write) else $error("saved write not 5 cycles");

  property p_ret_hit;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_LINK_RET) && !op_cond && !rs_if.empty &&
      (rs_if.top == op_target) |=> cycles_reg == 4'h4;
  endproperty
  a_ret_hit: assert property (p_ret_hit) else $error("return hit not 4");

  property p_two_issue;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_LOADSTORE) && ls_load && ls_reg_offset &&
      ls_offset_neg && !unaligned_en
      |=> (mem_cycles_reg == 4'h2) && (result_lat_reg == 4'h4) && !early_base_reg;
  endproperty
  a_two_issue: assert property (p_two_issue) else $error("two-issue load timing");

  property p_final_ua;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_LOADSTORE) && ls_load && !ls_reg_offset &&
      unaligned_en && ls_operand_unaligned && ls_final_unaligned
      |=> (result_lat_reg == 4'h4) && (mem_cycles_reg == 4'h2) && lsu_hold_reg;
  endproperty
  a_final_ua: assert property (p_final_ua) else $error("unaligned load timing");

  property p_fwd;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_LOADSTORE) && ls_writeback
      ##1 (state_reg == blit_pkg::ST_IDLE) && accept &&
      (op_class == blit_pkg::CL_LOADSTORE) && ls_writeback |=> base_lat_reg == 4'h0;
  endproperty
  a_fwd: assert property (p_fwd) else $error("base not forwarded");

  property p_preload_drop;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_PRELOAD) && preload_hit
      |=> preload_drop_reg && !result_valid_reg;
  endproperty
  a_preload_drop: assert property (p_preload_drop) else $error("preload not dropped");

  property p_pc_fail;
    @(posedge clk) disable iff (rst)
    accept && (op_class == blit_pkg::CL_PC_LOAD) && !op_cond_pass && !ls_reg_offset
      |=> (cycles_reg == 4'h1) && (result_lat_reg == 4'h3);
  endproperty
  a_pc_fail: assert property (p_pc_fail) else $error("failed pc load timing");
endmodule : blit_issue_timing

// ===== test/blit_mem_model.sv
// Behavioural memory system model that answers preload lookups.
`timescale 1ns/1ps
module blit_mem_model (
  // Outcome command from the bench.
  input wire logic [1:0] outcome,
  // Preload outcome seen by the pipeline.
  output logic preload_fault,
  output logic preload_hit,
  output logic preload_abort
);
  // Code 0 is a clean miss that fetches; 1 is a fault, 2 a hit and 3 an abort.
  always_comb begin
    preload_fault = (outcome == 2'h1);
    preload_hit = (outcome == 2'h2);
    preload_abort = (outcome == 2'h3);
  end
endmodule : blit_mem_model

// ===== test/test_branch_loadstore_issue_timing.sv
// Self-checking bench for the issue timing block.
`timescale 1ns/1ps
module test_branch_loadstore_issue_timing;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, op_valid = 1'b0, flag_set = 1'b0;
  blit_pkg::blit_class_t op_class = blit_pkg::CL_OTHER;
  logic op_cond = 1'b0, op_cond_pass = 1'b1, op_taken = 1'b1, op_link = 1'b0;
  logic [31:0] op_target = 32'h0, op_ret_addr = 32'h0;
  logic pred_dynamic = 1'b0, pred_dyn_correct = 1'b0, pred_folded = 1'b0;
  logic pred_static_taken = 1'b0, sr_saved = 1'b0, sr_flags_status_only = 1'b0;
  logic mask_mode_change = 1'b0, ls_load = 1'b1, ls_reg_offset = 1'b0, ls_offset_neg = 1'b0;
  logic ls_shift_ok = 1'b0, ls_writeback = 1'b0, ls_base_sp = 1'b0, unaligned_en = 1'b1;
  logic ls_operand_unaligned = 1'b0, ls_final_unaligned = 1'b0, exp_drop = 1'b0;
  logic [1:0] outcome = 2'h0;
  logic preload_fault, preload_hit, preload_abort, issue_ready_reg, done_reg, result_valid_reg;
  logic early_base_reg, early_offset_reg, lsu_hold_reg, preload_drop_reg, mispredict_reg;
  logic [3:0] cycles_reg, mem_cycles_reg, result_lat_reg, base_lat_reg;
  int n_mismatch = 0;
  int tests_run = 0;

  blit_issue_timing blit_issue_timing_inst (
    .clk, .rst, .ce, .op_valid, .op_class, .op_cond, .op_cond_pass, .op_taken, .op_link,
    .op_target, .op_ret_addr, .pred_dynamic, .pred_dyn_correct, .pred_folded,
    .pred_static_taken, .flag_set, .sr_saved, .sr_flags_status_only, .mask_mode_change,
    .ls_load, .ls_reg_offset, .ls_offset_neg, .ls_shift_ok, .ls_writeback, .ls_base_sp,
    .unaligned_en, .ls_operand_unaligned, .ls_final_unaligned, .preload_fault,
    .preload_hit, .preload_abort, .issue_ready_reg, .done_reg, .cycles_reg, .mem_cycles_reg,
    .result_lat_reg, .result_valid_reg, .early_base_reg, .early_offset_reg, .base_lat_reg,
    .lsu_hold_reg, .preload_drop_reg, .mispredict_reg
  );

  blit_mem_model blit_mem_model_inst (.outcome, .preload_fault, .preload_hit, .preload_abort);

  // The clock toggles every half period of 20 ns.
  always #20 clk = ~clk;

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Offers one instruction and measures the edges until done pulses.
  task automatic run(input blit_pkg::blit_class_t c, input logic [3:0] e);
    int n;
    op_class = c;
    op_valid = 1'b1;
    @(negedge clk);
    // Short instructions may be followed at once, so valid stays up for them.
    if (e > 4'h1) begin
      op_valid = 1'b0;
    end
    n = 1;
    chk(cycles_reg, e, "cycle count");
    chk(4'(issue_ready_reg), (e > 4'h1) ? 4'h0 : 4'h1, "issue ready");
    chk(4'(preload_drop_reg), 4'(exp_drop), "preload drop");
    while (done_reg !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(4'(n), (e == 4'h0) ? 4'h1 : e, "done timing");
  endtask : run

  task automatic br(input logic dy, cr, fo, st, input logic [3:0] e);
    pred_dynamic = dy;
    pred_dyn_correct = cr;
    pred_folded = fo;
    pred_static_taken = st;
    run(blit_pkg::CL_BRANCH, e);
  endtask : br

  // A taken link branch pushes its return address.
  task automatic push(input logic [31:0] a);
    op_link = 1'b1;
    op_ret_addr = a;
    br(1'b1, 1'b1, 1'b0, 1'b0, 4'h1);
  endtask : push

  task automatic pcl(input logic [31:0] t, input logic [3:0] e);
    op_target = t;
    run(blit_pkg::CL_PC_LOAD, e);
  endtask : pcl

  task automatic t_branch;
    op_taken = 1'b0;
    br(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
    op_taken = 1'b1;
    br(1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
    br(1'b1, 1'b1, 1'b0, 1'b0, 4'h1);
    br(1'b0, 1'b0, 1'b0, 1'b1, 4'h4);
    br(1'b0, 1'b0, 1'b0, 1'b0, 4'h5);
    chk(4'(mispredict_reg), 4'h1, "mispredict flag");
    op_cond = 1'b1;
    op_taken = 1'b0;
    run(blit_pkg::CL_REG_BR, 4'h1);
    op_cond = 1'b0;
    op_taken = 1'b1;
    run(blit_pkg::CL_REG_BR, 4'h5);
    // A flag setter just before a mispredict raises the penalty.
    flag_set = 1'b1;
    @(negedge clk);
    flag_set = 1'b0;
    br(1'b0, 1'b0, 1'b0, 1'b0, 4'h7);
    flag_set = 1'b1;
    @(negedge clk);
    flag_set = 1'b0;
    @(negedge clk);
    br(1'b0, 1'b0, 1'b0, 1'b0, 4'h6);
  endtask : t_branch

  // Return stack: empty, hit, miss, overflow drop and return loads.
  task automatic t_ret;
    op_target = 32'h100;
    run(blit_pkg::CL_LINK_RET, 4'h5);
    push(32'h100);
    run(blit_pkg::CL_LINK_RET, 4'h4);
    push(32'h200);
    run(blit_pkg::CL_LINK_RET, 4'h7);
    for (int i = 1; i <= 4; i++) push(32'(i * 16));
    ls_base_sp = 1'b1;
    for (int i = 4; i >= 2; i--) pcl(32'(i * 16), 4'h4);
    pcl(32'h10, 4'h8);
    push(32'h50);
    pcl(32'h60, 4'h9);
    chk(mem_cycles_reg, 4'h1, "return memory cycles");
    push(32'h70);
    op_cond = 1'b1;
    pcl(32'h70, 4'h8);
    op_cond = 1'b0;
    op_link = 1'b0;
  endtask : t_ret

  task automatic t_status;
    run(blit_pkg::CL_SR_READ, 4'h1);
    sr_saved = 1'b1;
    sr_flags_status_only = 1'b1;
    run(blit_pkg::CL_SR_WRITE, 4'h5);
    sr_saved = 1'b0;
    run(blit_pkg::CL_SR_WRITE, 4'h2);
    sr_flags_status_only = 1'b0;
    run(blit_pkg::CL_SR_WRITE, 4'h4);
    run(blit_pkg::CL_MASK_CHANGE, 4'h1);
    mask_mode_change = 1'b1;
    run(blit_pkg::CL_MASK_CHANGE, 4'h2);
    run(blit_pkg::CL_ENDIAN, 4'h1);
  endtask : t_status

  task automatic ls(input logic ro, ng, so, ou, fu, input logic [3:0] c, m, l);
    logic one;
    one = !ro || (!ng && so);
    ls_reg_offset = ro;
    ls_offset_neg = ng;
    ls_shift_ok = so;
    ls_operand_unaligned = ou;
    ls_final_unaligned = fu;
    run(blit_pkg::CL_LOADSTORE, c);
    chk(mem_cycles_reg, m, "memory cycles");
    chk(result_lat_reg, l, "result latency");
    chk({1'b0, early_base_reg, early_offset_reg, lsu_hold_reg},
        {1'b0, one, ro, unaligned_en & ou}, "early and hold");
  endtask : ls

  task automatic t_ls;
    ls_base_sp = 1'b0;
    ls(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 4'h3);
    chk(4'(result_valid_reg), 4'h1, "load result");
    ls(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 4'h1, 4'h3);
    ls(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2, 4'h2, 4'h4);
    ls(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 4'h2, 4'h4);
    ls(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h1, 4'h2, 4'h3);
    ls(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h2, 4'h3, 4'h4);
    ls(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h1, 4'h2, 4'h4);
    unaligned_en = 1'b0;
    ls(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h1, 4'h1, 4'h3);
    unaligned_en = 1'b1;
    ls_writeback = 1'b1;
    ls(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 4'h3);
    chk(base_lat_reg, 4'h1, "base latency");
    ls_load = 1'b0;
    ls(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 4'h3);
    chk(base_lat_reg, 4'h0, "forwarded base");
    chk(4'(result_valid_reg), 4'h0, "store result");
    ls_writeback = 1'b0;
    ls_load = 1'b1;
  endtask : t_ls

  // Preload with each memory outcome; all but a clean miss are dropped.
  task automatic t_preload;
    for (int k = 0; k < 4; k++) begin
      outcome = 2'(k);
      exp_drop = (k != 0);
      run(blit_pkg::CL_PRELOAD, 4'h1);
      chk(4'(result_valid_reg), 4'h0, "preload result");
      chk(mem_cycles_reg, 4'h1, "preload memory");
    end
    exp_drop = 1'b0;
    outcome = 2'h0;
  endtask : t_preload

  // Program counter loads that are not returns, and a failing one.
  task automatic t_pcl;
    ls(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 4'h3);
    pcl(32'h0, 4'h8);
    ls_reg_offset = 1'b1;
    ls_offset_neg = 1'b1;
    ls_operand_unaligned = 1'b1;
    ls_final_unaligned = 1'b1;
    pcl(32'h0, 4'h9);
    chk(mem_cycles_reg, 4'h2, "counter load memory");
    ls_reg_offset = 1'b0;
    op_cond = 1'b1;
    op_cond_pass = 1'b0;
    pcl(32'h0, 4'h1);
    chk(result_lat_reg, 4'h3, "failed load latency");
  endtask : t_pcl

  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Main sequence after ten reset cycles.
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_branch;
    t_ret;
    t_status;
    t_ls;
    t_preload;
    t_pcl;
    close_out;
  end

  // Watchdog well beyond the about 160 cycles the tests need.
  initial begin
    #400000;
    n_mismatch++;
    close_out;
  end
endmodule : test_branch_loadstore_issue_timing
